// >>> rtl/bcit_pkg.sv
/*
 * bcit_pkg: shared constants and the opcode timing table of the
 * byte cpu instruction timing block.
 * assumes: the classic 8-bit opcode map; single system clock timing.
 */
package bcit_pkg;

    // ******************************************************************
    // widths and bounds
    // ******************************************************************
    localparam int unsigned OP_W      = 8;
    localparam int unsigned PC_W      = 16;
    localparam int unsigned CNT_W     = 4;
    localparam int unsigned LEN_W     = 2;
    localparam logic [CNT_W-1:0] MAX_CLOCKS = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;

    // ******************************************************************
    // opcodes of the external-data write forms
    // ******************************************************************
    localparam logic [OP_W-1:0] OP_XWR_DPTR = 8'hF0;
    localparam logic [OP_W-1:0] OP_XWR_R0   = 8'hF2;
    localparam logic [OP_W-1:0] OP_XWR_R1   = 8'hF3;

    // decoded timing of one opcode
    typedef struct packed {
        logic             cond;  // conditional branch
        logic [LEN_W-1:0] len;   // program bytes
        logic [CNT_W-1:0] clk;   // clocks when taken
    } bcit_dec_t;

    // ******************************************************************
    // timing table: bytes and clocks for every opcode
    // ******************************************************************
    function automatic bcit_dec_t bcit_decode(input logic [OP_W-1:0] op);
        bcit_dec_t d;
        d = '{cond: 1'b0, len: 2'h1, clk: 4'h1};
        if (op[3]) begin
            // working register forms
            unique case (op[7:4])
                4'h7, 4'h8, 4'hA: d = '{1'b0, 2'h2, 4'h2};
                4'hB:             d = '{1'b1, 2'h3, 4'h4};
                4'hD:             d = '{1'b1, 2'h2, 4'h3};
                default:          d = '{1'b0, 2'h1, 4'h1};
            endcase
        end else begin
            unique case (op[2:0])
                3'h6, 3'h7: begin
                    // indirect pointer register forms: one byte, two clocks, except rows 7, 8, A (two bytes) and B (three bytes, five clocks)
                    unique case (op[7:4])
                        4'h7, 4'h8, 4'hA: d = '{1'b0, 2'h2, 4'h2};
                        4'hB:             d = '{1'b1, 2'h3, 4'h5};
                        default:          d = '{1'b0, 2'h1, 4'h2};
                    endcase
                end
                3'h5: begin
                    unique case (op[7:4])
                        4'h7, 4'h8: d = '{1'b0, 2'h3, 4'h3};
                        4'hA:       d = '{1'b0, 2'h1, 4'h1};
                        4'hB, 4'hD: d = '{1'b1, 2'h3, 4'h4};
                        default:    d = '{1'b0, 2'h2, 4'h2};
                    endcase
                end
                3'h4: begin
                    unique case (op[7:4])
                        4'h8:                    d = '{1'b0, 2'h1, 4'h8};
                        4'hA:                    d = '{1'b0, 2'h1, 4'h4};
                        4'hB:                    d = '{1'b1, 2'h3, 4'h4};
                        4'h0, 4'h1, 4'hC, 4'hD,
                        4'hE, 4'hF:              d = '{1'b0, 2'h1, 4'h1};
                        default:                 d = '{1'b0, 2'h2, 4'h2};
                    endcase
                end
                3'h3: begin
                    unique case (op[7:4])
                        4'h4, 4'h5, 4'h6:        d = '{1'b0, 2'h3, 4'h3};
                        4'h7, 4'h8, 4'h9,
                        4'hE, 4'hF:              d = '{1'b0, 2'h1, 4'h3};
                        default:                 d = '{1'b0, 2'h1, 4'h1};
                    endcase
                end
                3'h2: begin
                    unique case (op[7:4])
                        4'h0, 4'h1:              d = '{1'b0, 2'h3, 4'h4};
                        4'h2, 4'h3:              d = '{1'b0, 2'h1, 4'h5};
                        4'hE, 4'hF:              d = '{1'b0, 2'h1, 4'h3};
                        default:                 d = '{1'b0, 2'h2, 4'h2};
                    endcase
                end
                3'h1: d = '{1'b0, 2'h2, 4'h3};  // absolute jump and call
                default: begin
                    unique case (op[7:4])
                        4'h0:                    d = '{1'b0, 2'h1, 4'h1};
                        4'h1, 4'h2, 4'h3:        d = '{1'b1, 2'h3, 4'h4};
                        4'h4, 4'h5, 4'h6, 4'h7:  d = '{1'b1, 2'h2, 4'h3};
                        4'h8:                    d = '{1'b0, 2'h2, 4'h3};
                        4'h9:                    d = '{1'b0, 2'h3, 4'h3};
                        4'hE, 4'hF:              d = '{1'b0, 2'h1, 4'h3};
                        default:                 d = '{1'b0, 2'h2, 4'h2};
                    endcase
                end
            endcase
        end
        return d;
    endfunction : bcit_decode

endpackage : bcit_pkg

// >>> rtl/bcit_core.sv
/*
 * bcit_core: instruction issue and clock-count sequencer of the core.
 * assumes: the fetch stage presents one opcode byte per clock with its
 * branch condition already resolved; program flash and data RAM on chip.
 */
`timescale 1ns/10ps

// What this block does
// - opcodes decode exactly as in the classic 8-bit instruction set
// - timing counts only single system clocks, no machine cycles
// - most instructions take as many clocks as they have bytes
// - a conditional branch not taken ends one clock early
// - external-data writes go to on-chip program flash while the store write enable is set, else to on-chip xram
// - no off-chip memory bus exists; every access stays on chip
// - accumulator ops with a working register: one byte, one clock
// - accumulator ops with a direct byte: two bytes, two clocks
// - accumulator ops with an indirect pointer register: one byte, two clocks
// - accumulator ops with an immediate: two bytes, two clocks
// - logic immediate into a direct byte: three bytes, three clocks
// - direct to direct move: three bytes, three clocks
// - accumulator-only ops: one byte, one clock
// - indirect RAM to direct byte move: two bytes, two clocks
// - direct byte to working register move: two bytes, two clocks
// - no instruction takes more than eight clocks
// - relative target is next instruction address plus signed 8-bit offset
// - flash writes happen only while the store write enable is set
module bcit_core (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // opcode stream from fetch
    input  wire logic [bcit_pkg::OP_W-1:0]   op_byte,
    input  wire logic                        op_valid,
    input  wire logic                        branch_cond_met,
    input  wire logic [bcit_pkg::PC_W-1:0]   next_pc,
    input  wire logic [bcit_pkg::OP_W-1:0]   rel_offset,
    // program store control bit
    input  wire logic                        prog_store_wr_en,
    // sequencer status
    output logic                             op_ready_reg,
    output logic                             instr_done_reg,
    output logic [bcit_pkg::LEN_W-1:0]       instr_len_reg,
    output logic [bcit_pkg::CNT_W-1:0]       instr_clocks_reg,
    output logic [bcit_pkg::PC_W-1:0]        branch_target_reg,
    // on-chip write strobes
    output logic                             flash_wr_reg,
    output logic                             xram_wr_reg
);

    // ******************************************************************
    // decode and issue
    // ******************************************************************
    bcit_pkg::bcit_dec_t              dec;
    logic                             issue;
    logic                             is_xwr;
    logic [bcit_pkg::CNT_W-1:0]       count_reg, count_next;
    logic [bcit_pkg::CNT_W-1:0]       clocks_next;
    logic [bcit_pkg::LEN_W-1:0]       len_next;
    logic [bcit_pkg::PC_W-1:0]        target_next;
    logic                             xwr_reg, xwr_next;
    logic                             done_next, ready_next, flash_next, xram_next;

    // a new opcode is taken on the last clock of the previous one
    always_comb begin
        dec    = bcit_pkg::bcit_decode(op_byte);
        issue  = op_valid && (count_reg <= bcit_pkg::CNT_ONE);
        is_xwr = (op_byte == bcit_pkg::OP_XWR_DPTR) || (op_byte == bcit_pkg::OP_XWR_R0)
                 || (op_byte == bcit_pkg::OP_XWR_R1);
    end

    // ******************************************************************
    // clock counter
    // ******************************************************************
    // counting plain system clocks keeps the branch penalty a single subtraction
    always_comb begin
        count_next  = count_reg;
        clocks_next = instr_clocks_reg;
        len_next    = instr_len_reg;
        target_next = branch_target_reg;
        xwr_next    = xwr_reg;
        if (issue) begin
            clocks_next = (dec.cond && !branch_cond_met) ? dec.clk - bcit_pkg::CNT_ONE : dec.clk;
            count_next  = clocks_next;
            len_next    = dec.len;
            xwr_next    = is_xwr;
            target_next = next_pc + {{(bcit_pkg::PC_W-bcit_pkg::OP_W){rel_offset[7]}}, rel_offset};
        end else if (count_reg != bcit_pkg::CNT_ZERO) begin
            count_next  = count_reg - bcit_pkg::CNT_ONE;
        end
        done_next  = (count_reg == bcit_pkg::CNT_ONE);
        ready_next = (count_next <= bcit_pkg::CNT_ONE);
        // write lands in flash only with the enable set, else in on-chip xram
        flash_next = done_next && xwr_reg && prog_store_wr_en;
        xram_next  = done_next && xwr_reg && !prog_store_wr_en;
    end

    // registers of the sequencer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg         <= '0;
            instr_clocks_reg  <= '0;
            instr_len_reg     <= '0;
            branch_target_reg <= '0;
            xwr_reg           <= 1'b0;
            instr_done_reg    <= 1'b0;
            op_ready_reg      <= 1'b1;
            flash_wr_reg      <= 1'b0;
            xram_wr_reg       <= 1'b0;
        end else begin
            count_reg         <= count_next;
            instr_clocks_reg  <= clocks_next;
            instr_len_reg     <= len_next;
            branch_target_reg <= target_next;
            xwr_reg           <= xwr_next;
            instr_done_reg    <= done_next;
            op_ready_reg      <= ready_next;
            flash_wr_reg      <= flash_next;
            xram_wr_reg       <= xram_next;
        end
    end

    // ******************************************************************
    // checks
    // ******************************************************************
    clock_bound_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        count_reg <= bcit_pkg::MAX_CLOCKS) else $error("clock count above eight");
    reg_alu_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte[7:3] == 5'b00101 |=> instr_len_reg == 2'h1 && count_reg == 4'h1)
        else $error("register add timing wrong");
    direct_alu_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h25 |=> instr_len_reg == 2'h2 ##1 count_reg == 4'h1)
        else $error("direct add timing wrong");
    indirect_op_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h06 |=> instr_len_reg == 2'h1 && count_reg == 4'h2)
        else $error("indirect increment timing wrong");
    imm_alu_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h24 |=> instr_len_reg == 2'h2 && count_reg == 4'h2)
        else $error("immediate add timing wrong");
    rmw_imm_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h53 |=> instr_len_reg == 2'h3 && count_reg == 4'h3)
        else $error("logic immediate to direct timing wrong");
    move_dd_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h85 |=> instr_len_reg == 2'h3 && count_reg == 4'h3)
        else $error("direct move timing wrong");
    acc_only_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'hC4 |=> count_reg == 4'h1 ##1 instr_done_reg)
        else $error("swap not single clock");
    move_ind_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h86 |=> instr_len_reg == 2'h2 && count_reg == 4'h2)
        else $error("indirect to direct timing wrong");
    move_dreg_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'hA8 |=> instr_len_reg == 2'h2 && count_reg == 4'h2)
        else $error("direct to register timing wrong");
    branch_skip_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && op_byte == 8'h40 |=> count_reg == ($past(branch_cond_met) ? 4'h3 : 4'h2))
        else $error("branch not-taken penalty wrong");
    divide_done_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        // first cycle skipped: a back-to-back issue still shows the previous done pulse there
        issue && op_byte == 8'h84 |=> ##1 !instr_done_reg [*7] ##1 instr_done_reg)
        else $error("divide not done after eight clocks");
    rel_target_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue |=> branch_target_reg == $past(next_pc) + {{8{$past(rel_offset[7])}}, $past(rel_offset)})
        else $error("relative target wrong");
    flash_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        flash_wr_reg |-> $past(prog_store_wr_en) && !xram_wr_reg)
        else $error("flash written without enable");
    one_dptr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        issue && (op_byte == 8'hA3 || op_byte == 8'hD4) |=> count_reg == 4'h1 && instr_len_reg == 2'h1)
        else $error("pointer increment or decimal adjust not single clock");

endmodule : bcit_core

// >>> bench/bcit_store_model.sv
/*
 * bcit_store_model: on-chip program flash and data ram as seen from the
 * core, reduced to a tally of the write strobes that reach each space.
 * assumes: strobes are one-cycle pulses on the rising edge of sys_clk.
 */
`timescale 1ns/10ps

module bcit_store_model (
    // clock
    input  wire logic        sys_clk,
    // write strobes from the core
    input  wire logic        flash_wr,
    input  wire logic        xram_wr,
    // tallies for the bench
    output logic [15:0]      flash_cnt,
    output logic [15:0]      xram_cnt,
    output logic             bad_wr
);
    // ****************************************************************
    // write tallies
    // ****************************************************************
    // no reset: stored contents outlive a core reset, so do the tallies
    initial begin
        flash_cnt = 16'h0000;
        xram_cnt  = 16'h0000;
        bad_wr    = 1'b0;
    end

    // one write lands in exactly one on-chip space, never both
    always @(posedge sys_clk) begin
        flash_cnt <= flash_cnt + {15'h0000, flash_wr};
        xram_cnt  <= xram_cnt + {15'h0000, xram_wr};
        if (flash_wr && xram_wr) begin
            bad_wr <= 1'b1;
        end
    end
endmodule : bcit_store_model

// >>> bench/tb_top.sv
/*
 * tb_top: table-driven bench of the instruction timing sequencer.
 * assumes: bcit_pkg and bcit_core compiled first, store model beside.
 */
`timescale 1ns/10ps

module tb_top;
    logic        sys_clk, arst_n, op_valid, branch_cond_met, prog_store_wr_en;
    logic [7:0]  op_byte, rel_offset;
    logic [15:0] next_pc, branch_target_reg, fl_cnt, xr_cnt;
    logic        op_ready_reg, instr_done_reg, flash_wr_reg, xram_wr_reg, bad_wr;
    logic [1:0]  instr_len_reg;
    logic [3:0]  instr_clocks_reg;
    int          err_total, n_compared, k;

    // row: opcode, {condition met, store enable, bytes}, clocks
    logic [15:0] rows [$] = '{
        16'h2811, 16'h3F11, 16'h9811, 16'h5811, 16'h4D11, 16'h6A11,
        16'h2522, 16'h3522, 16'h9522, 16'h5522, 16'h4522, 16'h6522,
        16'h2612, 16'h3712, 16'h9612, 16'h0612, 16'h1712,
        16'h2422, 16'h3422, 16'h9422, 16'h5422, 16'h4422, 16'h6422,
        16'h5333, 16'h4333, 16'h6333, 16'h8533,
        16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
        16'hC411, 16'h8622, 16'h8722, 16'hA822, 16'hAF22,
        16'h8418, 16'hA414, 16'hA311, 16'hD411, 16'h0011, 16'hA511,
        16'h60A3, 16'h6022, 16'h30B4, 16'h3033, 16'hD8A3, 16'hD822,
        16'h40A3, 16'h4022,
        16'hB6B5, 16'hB634, 16'hF053, 16'hF213, 16'hF353
    };

    bcit_core dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .op_byte(op_byte), .op_valid(op_valid),
        .branch_cond_met(branch_cond_met), .next_pc(next_pc), .rel_offset(rel_offset),
        .prog_store_wr_en(prog_store_wr_en), .op_ready_reg(op_ready_reg),
        .instr_done_reg(instr_done_reg), .instr_len_reg(instr_len_reg),
        .instr_clocks_reg(instr_clocks_reg), .branch_target_reg(branch_target_reg),
        .flash_wr_reg(flash_wr_reg), .xram_wr_reg(xram_wr_reg));

    bcit_store_model store_u (.sys_clk(sys_clk), .flash_wr(flash_wr_reg), .xram_wr(xram_wr_reg),
        .flash_cnt(fl_cnt), .xram_cnt(xr_cnt), .bad_wr(bad_wr));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("compared=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // one instruction from issue to its done pulse; entered at a falling edge
    task automatic run_row(logic [15:0] r);
        logic mv;
        mv = r[15:8] inside {8'hF0, 8'hF2, 8'hF3};
        op_byte          = r[15:8];
        branch_cond_met  = r[7];
        prog_store_wr_en = r[6];
        next_pc          = {r[15:8], 8'hF0};
        rel_offset       = r[15:8];
        op_valid         = 1'b1;
        @(negedge sys_clk);
        op_valid = 1'b0;
        check(instr_len_reg, r[5:4]);
        check(instr_clocks_reg, r[3:0]);
        check(branch_target_reg, 16'({r[15:8], 8'hF0} + {{8{r[15]}}, r[15:8]}));
        k = 1;
        while (instr_done_reg !== 1'b1 && k < 12) begin
            @(negedge sys_clk);
            k++;
        end
        check(k, r[3:0] + 1);
        check(flash_wr_reg, mv & r[6]);
        check(xram_wr_reg, mv & !r[6]);
    endtask : run_row

    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // whole run is under 2000 cycles; a hang is cut well past that
    initial begin
        #50000;
        err_total++;
        wrap_up();
    end

    initial begin
        {arst_n, op_valid, branch_cond_met, prog_store_wr_en} = 4'h0;
        op_byte    = 8'h00;
        rel_offset = 8'h00;
        next_pc    = 16'h0000;
        err_total  = 0;
        n_compared = 0;
        repeat (5) @(negedge sys_clk);
        check({op_ready_reg, instr_done_reg, instr_len_reg, instr_clocks_reg, flash_wr_reg, xram_wr_reg},
            10'h200);
        arst_n = 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        // back to back issue, then an offer that must wait out a divide
        op_byte  = 8'h25;
        op_valid = 1'b1;
        @(negedge sys_clk);
        op_byte = 8'h84;
        @(negedge sys_clk);
        check(instr_clocks_reg, 4'h2);
        @(negedge sys_clk);
        check(instr_clocks_reg, 4'h8);
        op_byte = 8'h28;
        for (int e = 3; e < 10; e++) begin
            @(negedge sys_clk);
            check({instr_done_reg, op_ready_reg, instr_clocks_reg}, {1'b0, e == 9, 4'h8});
        end
        @(negedge sys_clk);
        check(instr_clocks_reg, 4'h1);
        op_byte = 8'h84;
        @(negedge sys_clk);
        op_valid = 1'b0;
        // reset in mid-divide, then a fresh instruction
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b0;
        @(negedge sys_clk);
        check({op_ready_reg, instr_done_reg, instr_len_reg, instr_clocks_reg, flash_wr_reg, xram_wr_reg},
            10'h200);
        arst_n = 1'b1;
        run_row(16'hA311);
        check(fl_cnt, 16'h0002);
        check(xr_cnt, 16'h0001);
        check(bad_wr, 1'b0);
        wrap_up();
    end
endmodule : tb_top
